// [rtl/pulse_generator.sv]
`timescale 1ns/1ps

// ==========================================================
// Overview of operation
// - four channels, each 16-bit down counter
// - count clock phi, /4, /16, /64
// - counter loads FFFF at reset, start
// - buffered period reloads counter each cycle
// - buffered duty compared against running counter
// - buffers transfer to active on start and borrow
// - duty match sets output, wins ties
// - borrow clears output unless match
// - forced output constantly low or high
// - selectable polarity inverts pin waveform
// - interrupt on start, borrow, match, either
// - interrupt request doubles as DMA trigger
// - simultaneous start by software or external trigger
// - restart reinitializes a running channel
// - trigger edge rising, falling or both
// - each channel drives own output pin
module pulse_generator (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_trigger,
  output logic [3:0]       wave_out,
  output logic [3:0]       irq_req,
  output logic [3:0]       dma_req
);

  localparam int N = pulse_generator_pkg::NUM_CH;

  typedef struct packed {
    pulse_generator_pkg::bus_state_t bus;
    logic                            aw_held;
    logic                            w_held;
    logic [7:0]                      waddr;
    logic [31:0]                     wdata;
    logic [3:0]                      wstrb;
    logic [31:0]                     rdata;
    logic                            unmapped;
    logic [3:0]                      sw_start;
    logic [3:0]                      ext_enable;
    logic                            trig_prev;
    logic [N-1:0][15:0]              period;
    logic [N-1:0][15:0]              duty;
    logic [N-1:0][15:0]              control;
  } top_state_t;

  top_state_t                         state;
  top_state_t                         next_state;
  pulse_generator_pkg::ch_cfg_t [N-1:0]  cfg;
  pulse_generator_pkg::ch_stat_t [N-1:0] stat;
  logic [N-1:0]                       start;
  logic [N-1:0]                       trig_hit;
  logic [N-1:0]                       pin;
  logic                               tick4;
  logic                               tick16;
  logic                               tick64;
  logic                               wr_go;
  logic [3:0]                         wch;
  logic [3:0]                         rch;
  logic [31:0]                        rd_word;
  logic                               rd_ok;
  logic [15:0]                        wmerge;

  // ==========================================================
  // shared prescaler
  prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick4   (tick4),
    .tick16  (tick16),
    .tick64  (tick64)
  );

  // ==========================================================
  // per channel: trigger edge detect, core, pin control
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic rise;
      logic fall;
      assign rise = ext_trigger & ~state.trig_prev;
      assign fall = ~ext_trigger & state.trig_prev;
      always_comb begin
        case (pulse_generator_pkg::edge_sel_t'(state.control[g][pulse_generator_pkg::CTL_EDGE_LO +: 2]))
          pulse_generator_pkg::EDGE_RISING:  trig_hit[g] = rise;
          pulse_generator_pkg::EDGE_FALLING: trig_hit[g] = fall;
          pulse_generator_pkg::EDGE_BOTH:    trig_hit[g] = rise | fall;
          default:                           trig_hit[g] = 1'b0;
        endcase
      end
      // one write or one shared trigger starts several channels together
      assign start[g] = state.sw_start[g] | (state.ext_enable[g] & trig_hit[g]);

      assign cfg[g].period  = state.period[g];
      assign cfg[g].duty    = state.duty[g];
      assign cfg[g].control = state.control[g];

      pulse_channel u_ch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick4   (tick4),
        .tick16  (tick16),
        .tick64  (tick64),
        .start   (start[g]),
        .cfg     (cfg[g]),
        .stat    (stat[g])
      );

      // force overrides the counter, polarity applies to the counter wave only
      always_comb begin
        if (state.control[g][pulse_generator_pkg::CTL_FORCE_EN]) begin
          pin[g] = state.control[g][pulse_generator_pkg::CTL_FORCE_LV];
        end else begin
          pin[g] = stat[g].wave ^ state.control[g][pulse_generator_pkg::CTL_INVERT];
        end
      end
      assign irq_req[g] = state.control[g][pulse_generator_pkg::CTL_IRQ_FLAG]
                          & state.control[g][pulse_generator_pkg::CTL_IRQ_EN];
      assign dma_req[g] = irq_req[g];
    end
  endgenerate

  // wave_out is registered so the pin never glitches on a config write
  logic [N-1:0] wave_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_q <= '0;
    end else begin
      wave_q <= pin;
    end
  end
  assign wave_out = wave_q;

  // ==========================================================
  // address decode
  assign wch = 4'((state.waddr - pulse_generator_pkg::OFF_CH_BASE) >> 4);
  assign rch = 4'((s_axi_araddr - pulse_generator_pkg::OFF_CH_BASE) >> 4);
  assign wr_go = (state.bus == pulse_generator_pkg::BUS_IDLE) && state.aw_held && state.w_held;

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr[1:0] != 2'b00) begin
      rd_ok = 1'b0;
    end else if (s_axi_araddr == pulse_generator_pkg::OFF_TRIG_ONE) begin
      rd_word = 32'h0000_0000;      // start bits self clear
    end else if (s_axi_araddr == pulse_generator_pkg::OFF_TRIG_TWO) begin
      rd_word = {28'h0000000, state.ext_enable};
    end else if (s_axi_araddr >= pulse_generator_pkg::OFF_CH_BASE && rch < 4'(N)) begin
      case (s_axi_araddr[3:0])
        pulse_generator_pkg::SUB_COUNT:   rd_word = {16'h0000, stat[rch[1:0]].count};
        pulse_generator_pkg::SUB_PERIOD:  rd_word = {16'h0000, state.period[rch[1:0]]};
        pulse_generator_pkg::SUB_DUTY:    rd_word = {16'h0000, state.duty[rch[1:0]]};
        pulse_generator_pkg::SUB_CONTROL: rd_word = {16'h0000, stat[rch[1:0]].running,
                                                     state.control[rch[1:0]][14:0]};
        default:                          rd_ok   = 1'b0;
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  // byte lane merge of the low half-word
  always_comb begin
    wmerge = 16'h0000;
    if (state.waddr[3:0] == pulse_generator_pkg::SUB_PERIOD) begin
      wmerge = state.period[wch[1:0]];
    end else if (state.waddr[3:0] == pulse_generator_pkg::SUB_DUTY) begin
      wmerge = state.duty[wch[1:0]];
    end else begin
      wmerge = state.control[wch[1:0]];
    end
    if (state.wstrb[0]) begin
      wmerge[7:0] = state.wdata[7:0];
    end
    if (state.wstrb[1]) begin
      wmerge[15:8] = state.wdata[15:8];
    end
  end

  // ==========================================================
  // bus slave and register file
  always_comb begin
    next_state           = state;
    next_state.sw_start  = 4'h0;
    next_state.trig_prev = ext_trigger;
    if (s_axi_awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held) begin
      next_state.w_held = 1'b1;
      next_state.wdata  = s_axi_wdata;
      next_state.wstrb  = s_axi_wstrb;
    end
    // sticky flags: hardware set wins over a software clear
    for (int i = 0; i < N; i++) begin
      if (stat[i].irq_set) begin
        next_state.control[i][pulse_generator_pkg::CTL_IRQ_FLAG] = 1'b1;
      end
    end
    case (state.bus)
      pulse_generator_pkg::BUS_IDLE: begin
        if (wr_go) begin
          next_state.aw_held  = 1'b0;
          next_state.w_held   = 1'b0;
          next_state.unmapped = 1'b0;
          next_state.bus      = pulse_generator_pkg::BUS_WRESP;
          if (state.waddr == pulse_generator_pkg::OFF_TRIG_ONE) begin
            next_state.sw_start = state.wdata[3:0] & {4{state.wstrb[0]}};
          end else if (state.waddr == pulse_generator_pkg::OFF_TRIG_TWO) begin
            if (state.wstrb[0]) begin
              next_state.ext_enable = state.wdata[3:0];
            end
          end else if (state.waddr >= pulse_generator_pkg::OFF_CH_BASE && wch < 4'(N)
                       && state.waddr[1:0] == 2'b00) begin
            case (state.waddr[3:0])
              pulse_generator_pkg::SUB_PERIOD: next_state.period[wch[1:0]] = wmerge;
              pulse_generator_pkg::SUB_DUTY:   next_state.duty[wch[1:0]]   = wmerge;
              pulse_generator_pkg::SUB_CONTROL: begin
                next_state.control[wch[1:0]] = wmerge & pulse_generator_pkg::CTL_WMASK;
                if (stat[wch[1:0]].irq_set) begin
                  next_state.control[wch[1:0]][pulse_generator_pkg::CTL_IRQ_FLAG] = 1'b1;
                end
              end
              pulse_generator_pkg::SUB_COUNT: ;   // count is read only
              default: next_state.unmapped = 1'b1;
            endcase
          end else begin
            next_state.unmapped = 1'b1;
          end
        end else if (s_axi_arvalid) begin
          next_state.rdata    = rd_word;
          next_state.unmapped = !rd_ok;
          next_state.bus      = pulse_generator_pkg::BUS_RDATA;
        end
      end
      pulse_generator_pkg::BUS_WRESP: begin
        if (s_axi_bready) begin
          next_state.bus = pulse_generator_pkg::BUS_IDLE;
        end
      end
      pulse_generator_pkg::BUS_RDATA: begin
        if (s_axi_rready) begin
          next_state.bus = pulse_generator_pkg::BUS_IDLE;
        end
      end
      default: next_state.bus = pulse_generator_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready  = !state.w_held;
  assign s_axi_arready = (state.bus == pulse_generator_pkg::BUS_IDLE) && !wr_go;
  assign s_axi_bvalid  = (state.bus == pulse_generator_pkg::BUS_WRESP);
  assign s_axi_bresp   = state.unmapped ? 2'b10 : 2'b00;
  assign s_axi_rvalid  = (state.bus == pulse_generator_pkg::BUS_RDATA);
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.unmapped ? 2'b10 : 2'b00;

  // ==========================================================
  // checks
  // write answered two edges after both halves land on an idle bus
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && (state.bus == pulse_generator_pkg::BUS_IDLE) && !s_axi_arvalid;
  endsequence

  // latch edge, execute edge, then the response shows
  sequence s_write_answer;
    ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_taken |-> s_write_answer)
    else $error("write response not on time");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not on time");

  // pin control and channel behaviour
  a_force_pin_level: assert property (@(posedge aclk) disable iff (!aresetn)
    state.control[1][pulse_generator_pkg::CTL_FORCE_EN]
      |=> wave_out[1] == $past(state.control[1][pulse_generator_pkg::CTL_FORCE_LV]))
    else $error("forced pin level not driven");
  a_irq_dma_same: assert property (@(posedge aclk) disable iff (!aresetn)
    dma_req == irq_req)
    else $error("dma request differs from interrupt");
  a_start_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    start[0] && state.control[0][pulse_generator_pkg::CTL_ENABLE] |=> stat[0].running)
    else $error("start did not run channel");
  a_restart_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    start[1] && state.control[1][pulse_generator_pkg::CTL_ENABLE]
      && state.control[1][pulse_generator_pkg::CTL_RESTART]
      |=> stat[1].count == pulse_generator_pkg::CNT_RELOAD)
    else $error("restart did not reload counter");
  // undivided clock only, so every edge is a tick
  a_count_steps: assert property (@(posedge aclk) disable iff (!aresetn)
    stat[0].running && state.control[0][pulse_generator_pkg::CTL_ENABLE] && !start[0]
      && state.control[0][pulse_generator_pkg::CTL_CLK_LO +: 2] == 2'b00 && stat[0].count != 16'h0000
      |=> stat[0].count == $past(stat[0].count) - 16'h0001)
    else $error("counter did not step by one");
  a_idle_inactive: assert property (@(posedge aclk) disable iff (!aresetn)
    !stat[1].running && !state.control[1][pulse_generator_pkg::CTL_FORCE_EN]
      |-> pin[1] == state.control[1][pulse_generator_pkg::CTL_INVERT])
    else $error("idle channel output active");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    stat[2].irq_set |=> state.control[2][pulse_generator_pkg::CTL_IRQ_FLAG])
    else $error("event flag lost");
  a_sw_start_group: assert property (@(posedge aclk) disable iff (!aresetn)
    state.sw_start[1:0] == 2'b11 && state.control[0][pulse_generator_pkg::CTL_ENABLE]
      && state.control[1][pulse_generator_pkg::CTL_ENABLE]
      |=> stat[0].running && stat[1].running)
    else $error("simultaneous start missed");
  a_rising_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    state.control[2][pulse_generator_pkg::CTL_EDGE_LO +: 2] == 2'b01
      && !state.trig_prev && ext_trigger |-> trig_hit[2])
    else $error("rising trigger missed");
  a_pin_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> wave_out == $past(pin))
    else $error("pin not registered");

endmodule // pulse_generator

// [rtl/pulse_generator_pkg.sv]
package pulse_generator_pkg;

  // ==========================================================
  // geometry
  localparam int          NUM_CH       = 4;
  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_RELOAD   = 16'hffff;

  // ==========================================================
  // register map, one aligned word each, channel block stride 0x10
  localparam logic [7:0]  OFF_TRIG_ONE  = 8'h00;  // software start bits
  localparam logic [7:0]  OFF_TRIG_TWO  = 8'h04;  // external start enables
  localparam logic [7:0]  OFF_CH_BASE   = 8'h10;
  localparam logic [7:0]  OFF_CH_STRIDE = 8'h10;
  localparam logic [3:0]  SUB_COUNT     = 4'h0;
  localparam logic [3:0]  SUB_PERIOD    = 4'h4;
  localparam logic [3:0]  SUB_DUTY      = 4'h8;
  localparam logic [3:0]  SUB_CONTROL   = 4'hc;

  // control word fields (low half = channel_control_low)
  localparam int CTL_ENABLE   = 0;   // channel counting allowed
  localparam int CTL_RESTART  = 1;
  localparam int CTL_CLK_LO   = 2;   // 2 bits, clock select
  localparam int CTL_IRQ_LO   = 4;   // 2 bits, request source
  localparam int CTL_IRQ_EN   = 6;
  localparam int CTL_IRQ_FLAG = 7;   // sticky, write 0 to clear
  localparam int CTL_EDGE_LO  = 8;   // 2 bits, trigger edge
  localparam int CTL_FORCE_EN = 10;
  localparam int CTL_FORCE_LV = 11;
  localparam int CTL_INVERT   = 12;
  localparam int CTL_RUNNING  = 15;  // read only

  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'h1fff;

  // prescaler terminal counts for phi/4, phi/16, phi/64
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h0f;
  localparam logic [5:0] DIV64_LAST = 6'h3f;

  typedef enum logic [1:0] {
    CLK_PHI   = 2'b00,
    CLK_DIV4  = 2'b01,
    CLK_DIV16 = 2'b10,
    CLK_DIV64 = 2'b11
  } clk_sel_t;

  typedef enum logic [1:0] {
    IRQ_START  = 2'b00,
    IRQ_BORROW = 2'b01,
    IRQ_DUTY   = 2'b10,
    IRQ_EITHER = 2'b11
  } irq_sel_t;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } bus_state_t;

  // one channel's control/status as a carrier
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
    logic [15:0] control;
  } ch_cfg_t;

  typedef struct packed {
    logic [15:0] count;
    logic        running;
    logic        irq_set;
    logic        wave;
  } ch_stat_t;

endpackage

// [rtl/prescaler.sv]
`timescale 1ns/1ps

// ==========================================================
// shared phi/4, phi/16, phi/64 tick enables
module prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  output logic            tick4,
  output logic            tick16,
  output logic            tick64
);

  typedef struct packed {
    logic [5:0] div;
  } pre_state_t;

  pre_state_t state;
  pre_state_t next_state;

  // free running divider, ticks are decodes of one counter
  always_comb begin
    next_state     = state;
    next_state.div = state.div + 6'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick4  = (state.div[1:0] == pulse_generator_pkg::DIV4_LAST[1:0]);
  assign tick16 = (state.div[3:0] == pulse_generator_pkg::DIV16_LAST[3:0]);
  assign tick64 = (state.div == pulse_generator_pkg::DIV64_LAST);

endmodule // prescaler

// [rtl/pulse_channel.sv]
`timescale 1ns/1ps

// ==========================================================
// one pulse channel: counter, buffered period/duty, waveform bit
module pulse_channel (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             tick4,
  input  wire logic                             tick16,
  input  wire logic                             tick64,
  input  wire logic                             start,
  input  wire pulse_generator_pkg::ch_cfg_t     cfg,
  output pulse_generator_pkg::ch_stat_t         stat
);

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic [15:0] duty;
    logic        running;
    logic        wave;
    logic        irq_set;
  } chan_state_t;

  chan_state_t state;
  chan_state_t next_state;
  logic        tick;
  logic        borrow;
  logic        match;
  logic        fire;

  // count clock select
  always_comb begin
    case (pulse_generator_pkg::clk_sel_t'(cfg.control[pulse_generator_pkg::CTL_CLK_LO +: 2]))
      pulse_generator_pkg::CLK_PHI:   tick = 1'b1;
      pulse_generator_pkg::CLK_DIV4:  tick = tick4;
      pulse_generator_pkg::CLK_DIV16: tick = tick16;
      pulse_generator_pkg::CLK_DIV64: tick = tick64;
      default:                        tick = 1'b0;
    endcase
  end

  assign borrow = state.running && tick && (state.count == 16'h0000);
  assign match  = state.running && tick && (state.count == state.duty);

  // interrupt source select
  always_comb begin
    case (pulse_generator_pkg::irq_sel_t'(cfg.control[pulse_generator_pkg::CTL_IRQ_LO +: 2]))
      pulse_generator_pkg::IRQ_START:  fire = start;
      pulse_generator_pkg::IRQ_BORROW: fire = borrow;
      pulse_generator_pkg::IRQ_DUTY:   fire = match;
      pulse_generator_pkg::IRQ_EITHER: fire = borrow | match;
      default:                         fire = 1'b0;
    endcase
  end

  // counter and pin state; a disabled channel reloads FFFF and drops the wave
  always_comb begin
    next_state         = state;
    next_state.irq_set = fire;
    if (!cfg.control[pulse_generator_pkg::CTL_ENABLE]) begin
      next_state.running = 1'b0;
      next_state.count   = pulse_generator_pkg::CNT_RELOAD;
      next_state.wave    = 1'b0;
    end else if (start && (!state.running || cfg.control[pulse_generator_pkg::CTL_RESTART])) begin
      next_state.running = 1'b1;
      next_state.count   = pulse_generator_pkg::CNT_RELOAD;
      next_state.wave    = 1'b0;
      next_state.period  = cfg.period;
      next_state.duty    = cfg.duty;
    end else if (state.running && tick) begin
      if (borrow) begin
        next_state.count  = state.period;
        next_state.period = cfg.period;
        next_state.duty   = cfg.duty;
      end else begin
        next_state.count = state.count - 16'h0001;
      end
      if (match) begin
        next_state.wave = 1'b1;
      end else if (borrow) begin
        next_state.wave = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '{count: pulse_generator_pkg::CNT_RELOAD, period: 16'h0000, duty: 16'h0000,
                 running: 1'b0, wave: 1'b0, irq_set: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign stat.count   = state.count;
  assign stat.running = state.running;
  assign stat.irq_set = state.irq_set;
  assign stat.wave    = state.wave;

endmodule // pulse_channel

// [tb/pwm_load.sv]
`timescale 1ns/1ps

// ==========================================================
// load on one pulse output pin: counts cycles spent high
module pwm_load (
  input  wire logic aclk,
  input  wire logic wave,
  input  wire logic clear,
  output int        highs
);
  // only a solid high counts, so an unknown pin never inflates the figure
  always @(posedge aclk) begin
    if (clear)
      highs <= 0;
    else
      highs <= highs + ((wave === 1'b1) ? 1 : 0);
  end
endmodule // pwm_load

// [tb/tb.sv]
`timescale 1ns/1ps

// ==========================================================
// bench for the four channel pulse generator
module tb;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, trig = 0, clr = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0]  bresp, rresp;
  logic        awr, wr_rdy, bv, arr, rv;
  logic [3:0]  wave, irq, dma;
  int          highs, errors = 0, checks = 0;

  always #50 aclk = ~aclk;

  pulse_generator i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .ext_trigger(trig), .wave_out(wave), .irq_req(irq), .dma_req(dma));

  pwm_load i_load (.aclk(aclk), .wave(wave[0]), .clear(clr), .highs(highs));

  // ==========================================================
  // compare, bus cycles, model
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
      if (bv) break;
    end
    bry <= 0;
    chk(bresp, 0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rry <= 0;
    d = rdat;
    chk(rresp, er);
  endtask

  function automatic logic [7:0] ca(int n, logic [3:0] sub);
    return pulse_generator_pkg::OFF_CH_BASE + pulse_generator_pkg::OFF_CH_STRIDE * n[7:0] + {4'h0, sub};
  endfunction

  // high cycles in a window: match sets, borrow clears, a tie stays high
  function automatic int exp_high(int duty, int per, int win);
    return (duty == 0) ? win : win / (per + 1) * duty;
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog, sized above the 65536 cycle first period
  initial begin : watchdog
    repeat (90000) @(posedge aclk);
    errors++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin : main
    logic [31:0] v, c1, r;
    logic [15:0] cv [3];
    cv = '{16'h0c00, 16'h0400, 16'h1000};
    r = $urandom(52);
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(ca(0, pulse_generator_pkg::SUB_CONTROL), 0, v);
    chk(v, 0);
    rd(ca(0, pulse_generator_pkg::SUB_COUNT), 0, v);
    chk(v, 32'hffff);
    rd(8'hfc, 2'b10, v);
    r = $urandom;
    wr(ca(3, pulse_generator_pkg::SUB_PERIOD), r);
    rd(ca(3, pulse_generator_pkg::SUB_PERIOD), 0, v);
    chk(v, {16'h0, r[15:0]});
    $display("test registers done");
    // idle pin: forced high, forced low, then inverted
    for (int i = 0; i < 3; i++) begin
      wr(ca(1, pulse_generator_pkg::SUB_CONTROL), {16'h0, cv[i]});
      repeat (3) @(posedge aclk);
      chk(wave[1], i != 1);
    end
    $display("test pin control done");
    wr(pulse_generator_pkg::OFF_TRIG_TWO, 32'h4);
    wr(ca(2, pulse_generator_pkg::SUB_CONTROL), 32'h0141);
    trig <= 1;
    repeat (4) @(posedge aclk);
    #1 chk(irq[2], 1);
    chk(dma[2], 1);
    rd(ca(2, pulse_generator_pkg::SUB_CONTROL), 0, v);
    chk(v[15], 1);
    wr(ca(2, pulse_generator_pkg::SUB_CONTROL), 32'h0141);
    repeat (2) @(posedge aclk);
    chk(irq[2], 0);
    $display("test external start done");
    wr(ca(0, pulse_generator_pkg::SUB_PERIOD), 3);
    wr(ca(0, pulse_generator_pkg::SUB_DUTY), 0);
    wr(ca(0, pulse_generator_pkg::SUB_CONTROL), 1);
    wr(ca(1, pulse_generator_pkg::SUB_CONTROL), 1);
    wr(ca(3, pulse_generator_pkg::SUB_CONTROL), 32'h000d);
    wr(pulse_generator_pkg::OFF_TRIG_ONE, 32'hb);
    rd(ca(0, pulse_generator_pkg::SUB_CONTROL), 0, v);
    chk(v[15], 1);
    rd(ca(1, pulse_generator_pkg::SUB_CONTROL), 0, v);
    chk(v[15], 1);
    rd(ca(0, pulse_generator_pkg::SUB_COUNT), 0, c1);
    rd(ca(0, pulse_generator_pkg::SUB_COUNT), 0, v);
    chk(v < c1, 1);
    // divide by 64: 640 cycles give 10 or 11 ticks
    rd(ca(3, pulse_generator_pkg::SUB_COUNT), 0, c1);
    repeat (640) @(posedge aclk);
    rd(ca(3, pulse_generator_pkg::SUB_COUNT), 0, v);
    chk((c1[15:0] - v[15:0]) >> 1, 5);
    $display("test start and count done");
    repeat (65600) @(posedge aclk);
    for (int d = 0; d < 4; d++) begin
      wr(ca(0, pulse_generator_pkg::SUB_DUTY), d);
      repeat (8) @(posedge aclk);
      clr <= 1;
      @(posedge aclk);
      clr <= 0;
      repeat (400) @(posedge aclk);
      #1 chk(highs, exp_high(d, 3, 400));
    end
    $display("test waveform done");
    // duty match request on ch0, then restart of a running ch1
    wr(ca(0, pulse_generator_pkg::SUB_CONTROL), 32'h0061);
    repeat (8) @(posedge aclk);
    chk(irq[0], 1);
    wr(ca(1, pulse_generator_pkg::SUB_CONTROL), 32'h0003);
    wr(pulse_generator_pkg::OFF_TRIG_ONE, 32'h2);
    rd(ca(1, pulse_generator_pkg::SUB_COUNT), 0, v);
    chk(v[15:8], 8'hff);
    $display("test duty request and restart done");
    print_verdict();
  end
endmodule // tb
